// ### design/gate_drive_current_map.svh
// register offsets, field positions and reset values of the drive current bank
`ifndef GATE_DRIVE_CURRENT_MAP_SVH
`define GATE_DRIVE_CURRENT_MAP_SVH
`define HB2_CFG_INDEX 8'h10
`define HB3_CFG_INDEX 8'h11
`define HB4_CFG_INDEX 8'h12
`define LOW_RANGE_INDEX 8'h15
`define BYTE_PER_INDEX 4
`define SOURCE_MSB 7
`define SOURCE_LSB 4
`define SINK_MSB 3
`define SINK_LSB 0
`define CFG_RESET 8'hff
`define LOW_RANGE_RESET 3'h0
`define CODE_RESET 4'hf
`define UA_RESET 16'd62000
`endif

// ### design/gate_drive_current_pkg.sv
// types shared by the drive current register bank
`default_nettype none
package gate_drive_current_pkg;
  typedef struct packed {
    logic [3:0] source_code;
    logic [3:0] sink_code;
    logic low_range;
    logic [15:0] source_ua;
    logic [15:0] sink_ua;
  } drive_setting_type;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
endpackage
`default_nettype wire

// ### design/gate_drive_current_cfg_regs.sv
// apb register bank of gate drive source and sink current codes, half-bridges 2 to 4
//
// The APB register port is this design's own decision.
`include "gate_drive_current_map.svh"
`default_nettype none
// Function
// R01: half-bridge 3 register sits at index 11h and resets to ffh.
// R02: half-bridge 4 register sits at index 12h and resets to ffh.
// R03: half-bridge 3 bits 7..4 are a read/write source code, reset 1111b, driving its gates.
// R04: half-bridge 3 bits 3..0 are a read/write sink code, reset 1111b.
// R05: half-bridge 2 bits 3..0 are a read/write sink code, reset 1111b.
// R06: half-bridge 4 holds source code in bits 7..4 and sink code in bits 3..0, both reset 1111b.
// R07: in normal range codes map to 0.5, 1..8, 12, 16, 20, 24, 31, 48, 62 mA.
// R08: with low range selected the codes map from 50 uA up to 2.3 mA.
// R09: half-bridge 2 register sits at index 10h, resets to ffh, source code in upper nibble.
// R10: reads return the last written or reset value and never change the drive settings.
module gate_drive_current_cfg_regs (
  input wire logic pclk, // apb clock, 50 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire gate_drive_current_pkg::apb_req_type apb_req, // apb request
  output var gate_drive_current_pkg::apb_rsp_type apb_rsp, // apb answer
  output var gate_drive_current_pkg::drive_setting_type [2:0] drive // [0]=hb2 .. [2]=hb4
);
  typedef struct packed {
    gate_drive_current_pkg::drive_setting_type [2:0] drv;
    gate_drive_current_pkg::apb_rsp_type rsp;
  } state_type;

  state_type s_q;
  state_type s_d;

  // current in microamps for a code; the low table trades range for resolution
  function automatic logic [15:0] current_ua(input logic [3:0] code, input logic low);
    logic [15:0] v;
    v = 16'h0000;
    if (low) begin // [R08]
      case (code)
        4'h0: v = 16'd50;
        4'h1: v = 16'd110;
        4'h2: v = 16'd170;
        4'h3: v = 16'd230;
        4'h4: v = 16'd290;
        4'h5: v = 16'd350;
        4'h6: v = 16'd410;
        4'h7: v = 16'd600;
        4'h8: v = 16'd725;
        4'h9: v = 16'd850;
        4'ha: v = 16'd1000;
        4'hb: v = 16'd1200;
        4'hc: v = 16'd1400;
        4'hd: v = 16'd1600;
        4'he: v = 16'd1800;
        default: v = 16'd2300;
      endcase
    end else begin // [R07]
      case (code)
        4'h0: v = 16'd500;
        4'h9: v = 16'd12000;
        4'ha: v = 16'd16000;
        4'hb: v = 16'd20000;
        4'hc: v = 16'd24000;
        4'hd: v = 16'd31000;
        4'he: v = 16'd48000;
        4'hf: v = 16'd62000;
        default: v = 16'({12'h000, code} * 16'd1000);
      endcase
    end
    return v;
  endfunction

  // byte address to bridge slot; 3 means the low range register, 4 unmapped
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    logic [2:0] r;
    r = 3'h4;
    if (addr == 32'(`HB2_CFG_INDEX * `BYTE_PER_INDEX)) r = 3'h0; // [R09]
    if (addr == 32'(`HB3_CFG_INDEX * `BYTE_PER_INDEX)) r = 3'h1; // [R01]
    if (addr == 32'(`HB4_CFG_INDEX * `BYTE_PER_INDEX)) r = 3'h2; // [R02]
    if (addr == 32'(`LOW_RANGE_INDEX * `BYTE_PER_INDEX)) r = 3'h3;
    return r;
  endfunction

  logic setup;
  logic wr_take;
  logic [2:0] slot;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_take = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite;
  assign slot = slot_of(apb_req.paddr);

  always_comb begin
    s_d = s_q;
    s_d.rsp.pready = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    // answer is prepared in the setup cycle so the access phase never waits
    if (setup) begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.prdata = 32'h0000_0000;
      s_d.rsp.pslverr = (slot == 3'h4);
      if (slot < 3'h3) begin // [R10]
        s_d.rsp.prdata[7:0] = {s_q.drv[slot].source_code, s_q.drv[slot].sink_code};
      end else if (slot == 3'h3) begin
        s_d.rsp.prdata[2:0] = {s_q.drv[2].low_range, s_q.drv[1].low_range,
                               s_q.drv[0].low_range};
      end
    end
    // only lane 0 carries data; a write without that strobe is ignored
    if (wr_take && apb_req.pstrb[0]) begin
      if (slot < 3'h3) begin // [R03] [R04] [R05] [R06]
        s_d.drv[slot].source_code = apb_req.pwdata[`SOURCE_MSB:`SOURCE_LSB];
        s_d.drv[slot].sink_code = apb_req.pwdata[`SINK_MSB:`SINK_LSB];
      end else if (slot == 3'h3) begin
        for (int i = 0; i < 3; i++) begin
          s_d.drv[i].low_range = apb_req.pwdata[i];
        end
      end
    end
    for (int i = 0; i < 3; i++) begin
      s_d.drv[i].source_ua = current_ua(s_d.drv[i].source_code, s_d.drv[i].low_range);
      s_d.drv[i].sink_ua = current_ua(s_d.drv[i].sink_code, s_d.drv[i].low_range);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin // [R01] [R02] [R09]
        s_q.drv[i].source_code <= `CODE_RESET;
        s_q.drv[i].sink_code <= `CODE_RESET;
        s_q.drv[i].low_range <= 1'b0;
        s_q.drv[i].source_ua <= `UA_RESET;
        s_q.drv[i].sink_ua <= `UA_RESET;
      end
      s_q.rsp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign drive = s_q.drv;

  a_hb3_write: assert property (@(posedge pclk) disable iff (!presetn) // [R03] [R04]
    wr_take && apb_req.pstrb[0] && slot == 3'h1 |=>
      {drive[1].source_code, drive[1].sink_code} == $past(apb_req.pwdata[7:0]))
    else $error("hb3 code not written");
  a_hb4_write: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    wr_take && apb_req.pstrb[0] && slot == 3'h2 |=>
      {drive[2].source_code, drive[2].sink_code} == $past(apb_req.pwdata[7:0]))
    else $error("hb4 code not written");
  a_hb2_write: assert property (@(posedge pclk) disable iff (!presetn) // [R05] [R09]
    wr_take && apb_req.pstrb[0] && slot == 3'h0 |=>
      drive[0].sink_code == $past(apb_req.pwdata[3:0]))
    else $error("hb2 code not written");
  a_read_back: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    setup && slot == 3'h1 |=>
      apb_rsp.prdata[7:0] == {$past(drive[1].source_code), $past(drive[1].sink_code)})
    else $error("hb3 read data wrong");
  a_read_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    !wr_take |=> $stable(drive[0].sink_code) && $stable(drive[2].source_code))
    else $error("setting changed without write");
  a_top_normal: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    drive[1].source_code == 4'hf && !drive[1].low_range |-> drive[1].source_ua == 16'd62000)
    else $error("normal range top wrong");
  a_low_bottom: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    drive[2].sink_code == 4'h0 && drive[2].low_range |-> drive[2].sink_ua == 16'd50)
    else $error("low range bottom wrong");
  a_ready_once: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    setup |=> apb_rsp.pready ##1 !apb_rsp.pready || setup)
    else $error("pready timing wrong");
  a_reset_max: assert property (@(posedge pclk) // [R02]
    $rose(presetn) |-> drive[2].source_code == 4'hf && drive[2].sink_code == 4'hf)
    else $error("hb4 reset value wrong");

  // writes: the hb2 upper nibble and the low range bits land as well
  a_hb2_source: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    wr_take && apb_req.pstrb[0] && slot == 3'h0 |=>
      drive[0].source_code == $past(apb_req.pwdata[7:4]))
    else $error("hb2 source code not written");
  a_low_write: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    wr_take && apb_req.pstrb[0] && slot == 3'h3 |=>
      {drive[2].low_range, drive[1].low_range, drive[0].low_range} ==
        $past(apb_req.pwdata[2:0]))
    else $error("low range bits not written");
  a_write_ignored: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
      (!apb_req.pstrb[0] || slot == 3'h4) |=> $stable(drive))
    else $error("ignored write changed a setting");

  // reads: each register shows the settings as they stood in the setup cycle
  a_read_hb2: assert property (@(posedge pclk) disable iff (!presetn) // [R05] [R09]
    setup && slot == 3'h0 |=>
      apb_rsp.prdata == {24'h0, $past(drive[0].source_code), $past(drive[0].sink_code)})
    else $error("hb2 read data wrong");
  a_read_hb4: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
    setup && slot == 3'h2 |=>
      apb_rsp.prdata == {24'h0, $past(drive[2].source_code), $past(drive[2].sink_code)})
    else $error("hb4 read data wrong");
  a_read_low: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    setup && slot == 3'h3 |=> apb_rsp.prdata == {29'h0, $past(drive[2].low_range),
      $past(drive[1].low_range), $past(drive[0].low_range)})
    else $error("low range read data wrong");
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    setup && slot == 3'h4 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_clean: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    setup && slot != 3'h4 |=> !apb_rsp.pslverr)
    else $error("mapped access refused");

  // code table spot checks at the normal range bottom, a normal range step at code 9 and the low range top
  a_bottom_normal: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    drive[1].source_code == 4'h0 && !drive[1].low_range |-> drive[1].source_ua == 16'd500)
    else $error("normal range bottom wrong");
  a_mid_normal: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    drive[2].sink_code == 4'h9 && !drive[2].low_range |-> drive[2].sink_ua == 16'd12000)
    else $error("normal range step wrong");
  a_top_low: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    drive[1].source_code == 4'hf && drive[1].low_range |-> drive[1].source_ua == 16'd2300)
    else $error("low range top wrong");
  a_sink_top_low: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    drive[1].sink_code == 4'hf && drive[1].low_range |-> drive[1].sink_ua == 16'd2300)
    else $error("low range sink top wrong");

  // reset: every bridge back at the strongest code, normal range, bus quiet
  a_reset_hb2: assert property (@(posedge pclk) // [R05] [R09]
    $rose(presetn) |-> drive[0].source_code == 4'hf && drive[0].sink_code == 4'hf)
    else $error("hb2 reset value wrong");
  a_reset_hb3: assert property (@(posedge pclk) // [R01] [R03] [R04]
    $rose(presetn) |-> drive[1].source_code == 4'hf && drive[1].sink_code == 4'hf)
    else $error("hb3 reset value wrong");
  a_reset_low: assert property (@(posedge pclk) // [R08]
    $rose(presetn) |-> !drive[0].low_range && !drive[1].low_range && !drive[2].low_range)
    else $error("low range reset value wrong");
  a_reset_bus: assert property (@(posedge pclk) // [R10]
    $rose(presetn) |-> !apb_rsp.pready && !apb_rsp.pslverr)
    else $error("bus answer not idle after reset");
endmodule
`default_nettype wire

// ### dv/gate_drive_current_cfg_regs_tb.sv
// self-checking bench of the gate drive current register bank over apb
`default_nettype none
module gate_drive_current_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  gate_drive_current_pkg::apb_req_type req = '0;
  gate_drive_current_pkg::apb_rsp_type rsp;
  gate_drive_current_pkg::drive_setting_type [2:0] drive;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h57;
  logic [31:0] d;
  logic [7:0] m[3];
  logic [3:0] k;
  logic lo;
  logic [15:0] nt[16] = '{16'h01f4, 16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0, 16'h1388, 16'h1770,
    16'h1b58, 16'h1f40, 16'h2ee0, 16'h3e80, 16'h4e20, 16'h5dc0, 16'h7918, 16'hbb80, 16'hf230};
  logic [15:0] lt[16] = '{16'h0032, 16'h006e, 16'h00aa, 16'h00e6, 16'h0122, 16'h015e, 16'h019a,
    16'h0258, 16'h02d5, 16'h0352, 16'h03e8, 16'h04b0, 16'h0578, 16'h0640, 16'h0708, 16'h08fc};
  int n_fail = 0;
  int n_compared = 0;
  function automatic logic [15:0] ua(input logic [3:0] c, input logic l);
    return l ? lt[c] : nt[c];
  endfunction
  gate_drive_current_cfg_regs uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .drive(drive));
  initial forever #10 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hold the request until pready is seen at an edge; a dead slave ends the run
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      input logic [3:0] s);
    int i;
    logic seen;
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= wd;
    req.pstrb <= s;
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    @(posedge pclk);
    req.penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rsp.pready !== 1'h1 && i < 50);
    seen = (rsp.pready === 1'h1);
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    // one idle edge, so the next call never rewrites psel in the same time step
    @(posedge pclk);
    if (!seen) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(a, 1'h0, 32'h0, 4'h0);
  endtask
  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'h1 && exp_q.size() > 0) begin
      check({8'h0, rsp.pslverr, rsp.prdata}, {8'h0, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      check(drive[i], {8'hff, 1'h0, 16'hf230, 16'hf230});
      rd(32'h40 + 32'(4 * i), {1'h0, 32'hff});
    end
    for (int i = 0; i < 3; i++) begin
      d = xs();
      m[i] = d[7:0];
      xfer(32'h40 + 32'(4 * i), 1'h1, d, 4'hf);
    end
    // a write with lane 0 disabled must leave hb4 alone
    xfer(32'h48, 1'h1, ~{24'h0, m[2]}, 4'h0);
    rd(32'h4c, {1'h1, 32'h0});
    for (int i = 0; i < 3; i++) begin
      rd(32'h40 + 32'(4 * i), {1'h0, 24'h0, m[i]});
      check(drive[i], {m[i], 1'h0, nt[m[i][7:4]], nt[m[i][3:0]]});
    end
    for (int r = 0; r < 2; r++) begin
      lo = r[0];
      xfer(32'h54, 1'h1, {29'h0, lo, lo, lo}, 4'hf);
      rd(32'h54, {1'h0, 29'h0, lo, lo, lo});
      check(drive[0], {m[0], lo, ua(m[0][7:4], lo), ua(m[0][3:0], lo)});
      for (int c = 0; c < 16; c++) begin
        k = c[3:0];
        xfer(32'h44, 1'h1, {24'h0, k, ~k}, 4'hf);
        xfer(32'h48, 1'h1, {24'h0, ~k, k}, 4'hf);
        @(posedge pclk);
        check(drive[1], {k, ~k, lo, ua(k, lo), ua(~k, lo)});
        check(drive[2], {~k, k, lo, ua(~k, lo), ua(k, lo)});
      end
    end
    // a second reset in mid-run must bring every setting back
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      check(drive[i], {8'hff, 1'h0, 16'hf230, 16'hf230});
    end
    rd(32'h54, {1'h0, 32'h0});
    rd(32'h44, {1'h0, 32'hff});
    check(41'(exp_q.size()), 41'h0);
    final_report();
  end
endmodule
`default_nettype wire
